// ---- verilog/satc_consts.svh ----
`ifndef SATC_CONSTS_SVH
`define SATC_CONSTS_SVH
// Register byte addresses
`define SATC_ADDR_REF_DIV      8'h04
`define SATC_ADDR_TIMER_CTRL   8'h80
`define SATC_ADDR_CELL_HDR     8'h84
`define SATC_ADDR_FLOW_CTRL    8'h88
`define SATC_ADDR_DELIN        8'h8c
`define SATC_ADDR_FRAMER       8'h90
`define SATC_ADDR_ALARM        8'h94
`define SATC_ADDR_ERROR        8'h98
`define SATC_ADDR_STATUS       8'h9c
// Reset values
`define SATC_RST_REF_DIV       16'h04bf
`define SATC_RST_TIMER         16'h0000
`define SATC_RST_CELL_HDR      16'h0000
`define SATC_RST_FLOW          16'h0000
`define SATC_RST_DELIN         16'h0076
`define SATC_RST_FRAMER        16'h0000
// Timer control fields
`define SATC_TMR_FM            12
`define SATC_TMR_PM            13
`define SATC_TMR_RT            14
`define SATC_TMR_FR            15
// Overhead byte values forced by insertion
`define SATC_LOP_PTR           16'h0f0f
`define SATC_AIS_PTR           16'hffff
`define SATC_SLM_LABEL         8'hec
`define SATC_A2_BYTE           8'h28
`endif

// ---- verilog/satc_pkg.sv ----
package satc_pkg;
    typedef enum logic [1:0] {SATC_UNFRAMED, SATC_STS1, SATC_STM1, SATC_STS3C} satc_format_e;
    typedef struct packed {
        logic       idle_gen_disable;
        logic       unassigned_discard_disable;
        logic       crc10_check_disable;
        logic       crc10_gen_disable;
        logic [2:0] vpi_bits;
        logic [3:0] vci_bits;
        logic       vci_code_invalid;
    } satc_cell_cfg_s;
    typedef struct packed {
        logic [11:0] credit_init_value;
        logic        counter_reset_null_en;
        logic        halt_nohalt_en;
    } satc_gfc_cfg_s;
    typedef struct packed {
        logic [3:0] sync_loss_count;
        logic [4:0] sync_gain_count;
        logic       payload_scramble_disable;
        logic       single_bit_correct_disable;
    } satc_delin_cfg_s;
    typedef struct packed {
        satc_format_e format;
        logic         frame_scramble_en;
        logic         parity_gen_en;
        logic         far_error_insert_en;
        logic         trace_en;
        logic         line_remote_defect_en;
        logic         path_remote_defect_en;
        logic         short_frame_test;
    } satc_framer_cfg_s;
    typedef struct packed {
        logic        force_ptr;
        logic [15:0] ptr_value;
        logic        force_label;
        logic [7:0]  label_value;
        logic        invert_a2;
        logic [15:0] other_alarms;
        logic [15:0] error_inserts;
    } satc_insert_s;
endpackage : satc_pkg

// ---- verilog/satc_control.sv ----
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ps
`include "satc_consts.svh"
// Behaviour
// - Divide line clock to ref_16khz_divider
// - Timer divides reference, timeout equals divisor/16 ms
// - Fault state change starts timer when enabled
// - Monitoring event starts timer when enabled
// - Run-timer bit starts timer immediately
// - Free-run reloads timer for periodic interrupts when started by run-timer bit
// - Two-bit code gives VPI bits 1..4
// - VCI bits are 7+code-P; 111 invalid
// - Idle or unassigned cells when no data
// - Unassigned cells discarded unless disable set
// - CRC-10 check disable stops discard only
// - GFC initial credit and protocol enables
// - Delineation gained after DELTA+1 good HECs
// - Delineation lost after SYNC_LOSS_COUNT bad HECs
// - Format field selects framing
// - Scrambling and BIP on unless disabled
// - FEBE inserted unless disabled
// - RDI and path trace on unless disabled
// - Pointer forced to 0f0f or ffff
// - C2 label overwritten on mismatch insertion
// - A2 bytes inverted for out-of-frame
module satc_control #(
    parameter int REF_DIV_W   = 12,
    parameter int TIMER_DIV_W = 12
) (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      clk_en,
    input  wire logic                      hsel,
    input  wire logic [7:0]                haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic      [31:0]               hrdata,
    output logic                           hreadyout,
    output logic                           hresp,
    input  wire logic                      line_tx_clock,
    input  wire logic                      fault_change,
    input  wire logic                      monitor_event,
    output logic                           ref_tick,
    output logic                           timer_irq,
    output satc_pkg::satc_cell_cfg_s       cell_cfg,
    output satc_pkg::satc_gfc_cfg_s        gfc_cfg,
    output satc_pkg::satc_delin_cfg_s      delin_cfg,
    output satc_pkg::satc_framer_cfg_s     framer_cfg,
    output satc_pkg::satc_insert_s         insert
);
    import satc_pkg::*;

    logic [15:0]            ref_16khz_divider;
    logic [15:0]            interrupt_timer_control;
    logic [15:0]            cell_header_config;
    logic [15:0]            flow_control_config;
    logic [15:0]            cell_delineation_config;
    logic [15:0]            framer_config;
    logic [15:0]            alarm_insertion;
    logic [15:0]            error_insertion;
    logic                   wr_pend;
    logic [7:0]             wr_addr;
    logic [REF_DIV_W-1:0]   ref_cnt;
    logic [TIMER_DIV_W-1:0] tmr_cnt;
    logic                   tmr_run;
    logic                   tmr_free;
    logic                   clk_q1;
    logic                   clk_q2;
    logic                   clk_q3;
    logic                   line_edge;
    logic                   rt_set;
    logic                   tmr_start;
    logic [REF_DIV_W-1:0]   ref_divisor;
    logic [TIMER_DIV_W-1:0] timer_divisor;

    // Register read decode, shared by the read path
    function automatic logic [15:0] reg_read(input logic [7:0] a);
        case (a)
            `SATC_ADDR_REF_DIV:    reg_read = ref_16khz_divider;
            `SATC_ADDR_TIMER_CTRL: reg_read = interrupt_timer_control;
            `SATC_ADDR_CELL_HDR:   reg_read = cell_header_config;
            `SATC_ADDR_FLOW_CTRL:  reg_read = flow_control_config;
            `SATC_ADDR_DELIN:      reg_read = cell_delineation_config;
            `SATC_ADDR_FRAMER:     reg_read = framer_config;
            `SATC_ADDR_ALARM:      reg_read = alarm_insertion;
            `SATC_ADDR_ERROR:      reg_read = error_insertion;
            `SATC_ADDR_STATUS:     reg_read = {14'h0000, tmr_free, tmr_run};
            default:               reg_read = 16'h0000;
        endcase
    endfunction : reg_read

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    // Capture write address phase; data follows next cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (clk_en) begin
            wr_pend <= hsel && hready && htrans[1] && hwrite;
            wr_addr <= haddr;
        end
    end

    // Read data registered at the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (clk_en && hsel && hready && htrans[1] && !hwrite) begin
            hrdata <= {16'h0000, reg_read(haddr)};
        end
    end

    // Register writes; run-timer self clears once the timer starts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_16khz_divider       <= `SATC_RST_REF_DIV;
            interrupt_timer_control <= `SATC_RST_TIMER;
            cell_header_config      <= `SATC_RST_CELL_HDR;
            flow_control_config     <= `SATC_RST_FLOW;
            cell_delineation_config <= `SATC_RST_DELIN;
            framer_config           <= `SATC_RST_FRAMER;
            alarm_insertion         <= 16'h0000;
            error_insertion         <= 16'h0000;
        end else if (clk_en) begin
            if (wr_pend) begin
                case (wr_addr)
                    `SATC_ADDR_REF_DIV:    ref_16khz_divider <= {4'h0, hwdata[11:0]};
                    `SATC_ADDR_TIMER_CTRL: interrupt_timer_control <= hwdata[15:0];
                    `SATC_ADDR_CELL_HDR:   cell_header_config <= hwdata[15:0] & 16'h0f73;
                    `SATC_ADDR_FLOW_CTRL:  flow_control_config <= hwdata[15:0] & 16'h3fff;
                    `SATC_ADDR_DELIN:      cell_delineation_config <= hwdata[15:0] & 16'h03ff;
                    `SATC_ADDR_FRAMER:     framer_config <= hwdata[15:0] & 16'h7f03;
                    `SATC_ADDR_ALARM:      alarm_insertion <= hwdata[15:0] & 16'h07ff;
                    `SATC_ADDR_ERROR:      error_insertion <= hwdata[15:0];
                    default: ;
                endcase
            end
            // Clear under other writes too, else back-to-back writes restart the timer
            if (rt_set && !(wr_pend && wr_addr == `SATC_ADDR_TIMER_CTRL)) begin
                interrupt_timer_control[`SATC_TMR_RT] <= 1'b0;
            end
        end
    end

    assign ref_divisor   = ref_16khz_divider[REF_DIV_W-1:0];
    assign timer_divisor = interrupt_timer_control[TIMER_DIV_W-1:0];
    assign rt_set        = interrupt_timer_control[`SATC_TMR_RT];

    // Line clock is slow against hclk; synchronise and sample its rising edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_q1 <= 1'b0;
            clk_q2 <= 1'b0;
            clk_q3 <= 1'b0;
        end else if (clk_en) begin
            clk_q1 <= line_tx_clock;
            clk_q2 <= clk_q1;
            clk_q3 <= clk_q2;
        end
    end
    assign line_edge = clk_q2 && !clk_q3;

    // Reference divider: one tick every ref_divisor line edges
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ref_cnt  <= '0;
            ref_tick <= 1'b0;
        end else if (clk_en) begin
            ref_tick <= 1'b0;
            if (line_edge) begin
                if (ref_cnt + 1'b1 >= ref_divisor) begin
                    ref_cnt  <= '0;
                    ref_tick <= 1'b1;
                end else begin
                    ref_cnt <= ref_cnt + 1'b1;
                end
            end
        end
    end

    assign tmr_start = rt_set
        || (interrupt_timer_control[`SATC_TMR_FM] && fault_change)
        || (interrupt_timer_control[`SATC_TMR_PM] && monitor_event);

    // Interrupt timer counts reference ticks; restart wins over expiry
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tmr_cnt   <= '0;
            tmr_run   <= 1'b0;
            tmr_free  <= 1'b0;
            timer_irq <= 1'b0;
        end else if (clk_en) begin
            timer_irq <= 1'b0;
            if (tmr_start) begin
                tmr_cnt  <= timer_divisor;
                tmr_run  <= 1'b1;
                tmr_free <= rt_set && interrupt_timer_control[`SATC_TMR_FR];
            end else if (tmr_run && ref_tick) begin
                if (tmr_cnt <= 1) begin
                    timer_irq <= 1'b1;
                    tmr_cnt   <= timer_divisor;
                    tmr_run   <= tmr_free && interrupt_timer_control[`SATC_TMR_FR];
                end else begin
                    tmr_cnt <= tmr_cnt - 1'b1;
                end
            end
        end
    end

    // Cell header configuration decode
    always_comb begin
        cell_cfg.idle_gen_disable           = cell_header_config[8];
        cell_cfg.unassigned_discard_disable = cell_header_config[9];
        cell_cfg.crc10_check_disable        = cell_header_config[10];
        cell_cfg.crc10_gen_disable          = cell_header_config[11];
        cell_cfg.vpi_bits = {1'b0, cell_header_config[1:0]} + 3'h1;
        cell_cfg.vci_bits = 4'h7 + {1'b0, cell_header_config[6:4]}
            - {1'b0, cell_cfg.vpi_bits};
        cell_cfg.vci_code_invalid = (cell_header_config[6:4] == 3'h7);
    end

    // GFC and delineation fields
    always_comb begin
        gfc_cfg.credit_init_value     = flow_control_config[11:0];
        gfc_cfg.counter_reset_null_en = flow_control_config[12];
        gfc_cfg.halt_nohalt_en        = flow_control_config[13];
        delin_cfg.sync_gain_count = {1'b0, cell_delineation_config[3:0]} + 5'h01;
        delin_cfg.sync_loss_count = cell_delineation_config[7:4];
        delin_cfg.payload_scramble_disable   = cell_delineation_config[8];
        delin_cfg.single_bit_correct_disable = cell_delineation_config[9];
    end

    // Framer enables: stored as disables so reset leaves features on
    always_comb begin
        framer_cfg.format                = satc_format_e'(framer_config[1:0]);
        framer_cfg.frame_scramble_en     = !framer_config[8];
        framer_cfg.parity_gen_en         = !framer_config[9];
        framer_cfg.far_error_insert_en   = !framer_config[10];
        framer_cfg.trace_en              = !framer_config[11];
        framer_cfg.line_remote_defect_en = !framer_config[12];
        framer_cfg.path_remote_defect_en = !framer_config[13];
        framer_cfg.short_frame_test      = framer_config[14];
    end

    // Overhead overrides follow the live register bits only
    always_comb begin
        insert.force_ptr    = alarm_insertion[3] || alarm_insertion[4];
        insert.ptr_value    = alarm_insertion[4] ? `SATC_AIS_PTR : `SATC_LOP_PTR;
        insert.force_label  = alarm_insertion[5];
        insert.label_value  = `SATC_SLM_LABEL;
        insert.invert_a2    = alarm_insertion[1];
        insert.other_alarms = alarm_insertion;
        insert.error_inserts = error_insertion;
    end

    // Checks
    sequence s_started;
        tmr_start && clk_en;
    endsequence
    property p_rt_runs;
        @(posedge hclk) disable iff (!hresetn) s_started |=> tmr_run;
    endproperty
    a_rt_runs: assert property (p_rt_runs) else $error("timer not running after start");
    property p_irq_needs_run;
        @(posedge hclk) disable iff (!hresetn) timer_irq |-> $past(tmr_run);
    endproperty
    a_irq_needs_run: assert property (p_irq_needs_run) else $error("irq without timer");
    property p_fm_start;
        @(posedge hclk) disable iff (!hresetn)
            clk_en && interrupt_timer_control[`SATC_TMR_FM] && fault_change |=> tmr_run;
    endproperty
    a_fm_start: assert property (p_fm_start) else $error("fault change did not start");
    property p_pm_start;
        @(posedge hclk) disable iff (!hresetn)
            clk_en && interrupt_timer_control[`SATC_TMR_PM] && monitor_event |=> tmr_run;
    endproperty
    a_pm_start: assert property (p_pm_start) else $error("monitor event did not start");
    property p_one_shot;
        @(posedge hclk) disable iff (!hresetn)
            timer_irq && !$past(tmr_free) && !$past(tmr_start) |-> !tmr_run;
    endproperty
    a_one_shot: assert property (p_one_shot) else $error("one-shot timer kept running");
    property p_tick_period;
        @(posedge hclk) disable iff (!hresetn) ref_tick && clk_en |=> !ref_tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("reference tick too long");
    property p_vci;
        @(posedge hclk) disable iff (!hresetn)
            cell_header_config[6:4] == 3'h0 && cell_header_config[1:0] == 2'h0
            |-> cell_cfg.vci_bits == 4'h6;
    endproperty
    a_vci: assert property (p_vci) else $error("vci width wrong");
    property p_ptr;
        @(posedge hclk) disable iff (!hresetn)
            alarm_insertion[4] |-> insert.force_ptr && insert.ptr_value == 16'hffff;
    endproperty
    a_ptr: assert property (p_ptr) else $error("ais pointer wrong");
    property p_gain;
        @(posedge hclk) disable iff (!hresetn)
            clk_en && wr_pend && wr_addr == `SATC_ADDR_DELIN
            |=> delin_cfg.sync_gain_count == {1'b0, $past(hwdata[3:0])} + 5'h01;
    endproperty
    a_gain: assert property (p_gain) else $error("gain count wrong");
    // Last tick of a running count, not masked by a restart
    sequence s_expiring;
        clk_en && !tmr_start && tmr_run && ref_tick && tmr_cnt <= 1;
    endsequence
    property p_expiry_irq;
        @(posedge hclk) disable iff (!hresetn) s_expiring |=> timer_irq;
    endproperty
    a_expiry_irq: assert property (p_expiry_irq) else $error("expiry without irq");
    property p_free_reload;
        @(posedge hclk) disable iff (!hresetn)
            s_expiring ##0 (tmr_free && interrupt_timer_control[`SATC_TMR_FR]) |=> tmr_run;
    endproperty
    a_free_reload: assert property (p_free_reload) else $error("free run stopped");
    property p_rt_clear;
        @(posedge hclk) disable iff (!hresetn)
            clk_en && rt_set && !wr_pend |=> !rt_set;
    endproperty
    a_rt_clear: assert property (p_rt_clear) else $error("run bit stuck");
    property p_tick_src;
        @(posedge hclk) disable iff (!hresetn) clk_en && !line_edge |=> !ref_tick;
    endproperty
    a_tick_src: assert property (p_tick_src) else $error("tick without line edge");
    property p_lop;
        @(posedge hclk) disable iff (!hresetn)
            alarm_insertion[3] && !alarm_insertion[4]
            |-> insert.force_ptr && insert.ptr_value == 16'h0f0f;
    endproperty
    a_lop: assert property (p_lop) else $error("lop pointer wrong");
    property p_label;
        @(posedge hclk) disable iff (!hresetn)
            alarm_insertion[5] |-> insert.force_label && insert.label_value == 8'hec;
    endproperty
    a_label: assert property (p_label) else $error("label not forced");
    property p_release;
        @(posedge hclk) disable iff (!hresetn)
            alarm_insertion[5:3] == 3'b000 |-> !insert.force_ptr && !insert.force_label;
    endproperty
    a_release: assert property (p_release) else $error("override outlived its bit");
endmodule : satc_control

// ---- testbench/satc_line_model.sv ----
`timescale 1ns/1ps
// Line transceiver stand-in: free transmit clock plus event pulses
module satc_line_model #(
    parameter int HALF_NS  = 40,
    parameter int PHASE_NS = 3
) (
    input  wire logic hclk,
    output logic      line_tx_clock,
    output logic      fault_change,
    output logic      monitor_event
);
    // Clock runs free; offset keeps its edges clear of hclk edges
    initial begin
        line_tx_clock = 1'b0;
        fault_change  = 1'b0;
        monitor_event = 1'b0;
        #(PHASE_NS);
        forever #(HALF_NS) line_tx_clock = ~line_tx_clock;
    end

    // One-cycle event pulse, launched just after a rising edge
    task automatic pulse(input logic pm);
        @(posedge hclk);
        if (pm) monitor_event <= 1'b1;
        else fault_change <= 1'b1;
        @(posedge hclk);
        fault_change  <= 1'b0;
        monitor_event <= 1'b0;
    endtask : pulse
endmodule : satc_line_model

// ---- testbench/satc_control_tb.sv ----
`timescale 1ns/1ps
`include "satc_consts.svh"
module satc_control_tb;
    import satc_pkg::*;
    logic              hclk    = 1'b0;
    logic              hresetn = 1'b0;
    logic              hsel    = 1'b0;
    logic              hwrite  = 1'b0;
    logic              rd_ph   = 1'b0;
    logic [7:0]        haddr   = 8'h00;
    logic [1:0]        htrans  = 2'b00;
    logic [31:0]       hwdata  = 32'h0;
    logic [31:0]       hrdata;
    logic              hreadyout, hresp, ref_tick, timer_irq;
    logic              line_tx_clock, fault_change, monitor_event;
    satc_cell_cfg_s    cell_cfg;
    satc_gfc_cfg_s     gfc_cfg;
    satc_delin_cfg_s   delin_cfg;
    satc_framer_cfg_s  framer_cfg;
    satc_insert_s      insert;
    logic [31:0]       rd_q[$];
    int                irq_q[$];
    int                tick_cnt, n_errors, comparisons, i, p, c, n;
    logic [15:0]       d;
    logic [15:0]       wv [8];
    logic [7:0]        ra [8] = '{`SATC_ADDR_REF_DIV, `SATC_ADDR_TIMER_CTRL, `SATC_ADDR_CELL_HDR,
        `SATC_ADDR_FLOW_CTRL, `SATC_ADDR_DELIN, `SATC_ADDR_FRAMER, `SATC_ADDR_ALARM,
        `SATC_ADDR_ERROR};
    logic [15:0]       rm [8] = '{16'h0fff, 16'hbfff, 16'h0f73, 16'h3fff, 16'h03ff, 16'h7f03,
        16'h07ff, 16'hffff};
    logic [15:0]       rv [8] = '{16'h04bf, 0, 0, 0, 16'h0076, 0, 0, 0};
    logic [15:0]       av [6] = '{16'h0008, 16'h0018, 16'h0010, 16'h0020, 16'h0002, 16'h0000};

    always #5 hclk = ~hclk;

    satc_control DUT (
        .hclk(hclk), .hresetn(hresetn), .clk_en(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .line_tx_clock(line_tx_clock),
        .fault_change(fault_change), .monitor_event(monitor_event), .ref_tick(ref_tick),
        .timer_irq(timer_irq), .cell_cfg(cell_cfg), .gfc_cfg(gfc_cfg), .delin_cfg(delin_cfg),
        .framer_cfg(framer_cfg), .insert(insert)
    );
    satc_line_model LINE (.hclk(hclk), .line_tx_clock(line_tx_clock),
        .fault_change(fault_change), .monitor_event(monitor_event));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Single word transfer; for reads dv is the expected data
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] dv);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= dv;
        if (!wr) rd_q.push_back(dv);
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : bus

    // Start just after a tick so no stray tick lands before the count restarts
    task automatic align;
        @(negedge hclk iff ref_tick === 1'b1);
    endtask : align

    task automatic arm(input int k);
        @(negedge hclk);
        tick_cnt = 0;
        irq_q.push_back(k);
    endtask : arm

    task automatic wrap_up;
        $display("Comparisons %0d, errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up

    // Result watcher: read data and timer interrupts against the noted queues
    always @(posedge hclk) begin
        if (rd_ph && hreadyout === 1'b1) chk({hrdata[31:1], hrdata[0] | hresp}, rd_q.pop_front());
        rd_ph <= hsel && htrans[1] && !hwrite;
        if (hresetn && ref_tick === 1'b1) tick_cnt++;
        if (hresetn && timer_irq === 1'b1) begin
            if (irq_q.size() == 0) chk(32'd1, 32'd0);
            else chk(tick_cnt, irq_q.pop_front());
            tick_cnt = 0;
        end
    end

    initial begin
        void'($urandom(68063));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        chk({delin_cfg.sync_gain_count, delin_cfg.sync_loss_count}, {5'd7, 4'd7});
        chk({framer_cfg.frame_scramble_en, framer_cfg.parity_gen_en}, 2'b11);
        for (i = 0; i < 8; i++) bus(1'b0, ra[i], {16'h0, rv[i]});
        bus(1'b1, 8'h40, 32'h1234);
        bus(1'b0, 8'h40, 32'h0);
        // Random fill then readback, idle cycles between transfers; upper half is dropped
        for (i = 0; i < 8; i++) begin
            wv[i] = 16'($urandom()) & rm[i];
            bus(1'b1, ra[i], {16'hffff, wv[i]});
        end
        for (i = 0; i < 8; i++) bus(1'b0, ra[i], {16'h0, wv[i]});
        chk(gfc_cfg, {wv[3][11:0], wv[3][12], wv[3][13]});
        chk(delin_cfg.sync_gain_count, 5'(wv[4][3:0]) + 5'd1);
        chk(delin_cfg.sync_loss_count, wv[4][7:4]);
        chk(insert.error_inserts, wv[7]);
        bus(1'b1, `SATC_ADDR_DELIN, 32'h00f0);
        @(negedge hclk);
        chk({delin_cfg.sync_gain_count, delin_cfg.sync_loss_count}, {5'd1, 4'hf});
        // Every header width code, flags at random
        for (p = 0; p < 4; p++) begin
            for (c = 0; c < 8; c++) begin
                d = {4'h0, 4'($urandom()), 1'b0, 3'(c), 2'b00, 2'(p)};
                bus(1'b1, `SATC_ADDR_CELL_HDR, {16'h0, d});
                @(negedge hclk);
                chk(cell_cfg.vpi_bits, p + 1);
                chk(cell_cfg.vci_code_invalid, c == 7);
                if (c != 7) chk(cell_cfg.vci_bits, 6 + c - p);
                chk({cell_cfg.idle_gen_disable, cell_cfg.unassigned_discard_disable,
                    cell_cfg.crc10_check_disable, cell_cfg.crc10_gen_disable},
                    {d[8], d[9], d[10], d[11]});
            end
        end
        for (i = 0; i < 4; i++) begin
            d = (16'($urandom()) & 16'h7f00) | 16'(i);
            bus(1'b1, `SATC_ADDR_FRAMER, {16'h0, d});
            @(negedge hclk);
            chk(framer_cfg, {2'(i), ~d[8], ~d[9], ~d[10], ~d[11], ~d[12], ~d[13],
                d[14]});
        end
        // Pointer, label and A2 forcing; last entry clears everything
        foreach (av[k]) begin
            bus(1'b1, `SATC_ADDR_ALARM, {16'h0, av[k]});
            @(negedge hclk);
            chk({insert.force_ptr, insert.force_label, insert.invert_a2},
                {av[k][3] | av[k][4], av[k][5], av[k][1]});
            if (av[k][4:3] != 2'b00) chk(insert.ptr_value, av[k][4] ? 16'hffff : 16'h0f0f);
            if (av[k][5]) chk(insert.label_value, 8'hec);
            chk(insert.other_alarms, av[k]);
        end
        // Short reference period keeps the timer runs brief
        bus(1'b1, `SATC_ADDR_REF_DIV, 32'h4);
        repeat (2) align();
        n = 0;
        do begin
            @(negedge hclk);
            n++;
        end while (ref_tick !== 1'b1);
        chk(n, 32);
        align();
        bus(1'b1, `SATC_ADDR_TIMER_CTRL, 32'h4003);
        arm(3);
        while (irq_q.size() != 0) @(negedge hclk);
        bus(1'b0, `SATC_ADDR_TIMER_CTRL, 32'h0003);
        for (i = 0; i < 2; i++) begin
            bus(1'b1, `SATC_ADDR_TIMER_CTRL, i ? 32'h2003 : 32'h1003);
            align();
            LINE.pulse(i[0]);
            arm(3);
            while (irq_q.size() != 0) @(negedge hclk);
            // Other trigger kind is disabled: the watcher flags any interrupt
            LINE.pulse(!i[0]);
            repeat (5) align();
        end
        align();
        bus(1'b1, `SATC_ADDR_TIMER_CTRL, 32'hc002);
        arm(2);
        irq_q.push_back(2);
        while (irq_q.size() != 0) @(negedge hclk);
        // Reset in mid-run stops the free-running timer and restores registers
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, `SATC_ADDR_REF_DIV, 32'h04bf);
        repeat (100) @(posedge hclk);
        wrap_up();
    end

    initial begin
        #200000;
        n_errors++;
        $display("[ERR] %0t: timeout", $time);
        wrap_up();
    end
endmodule : satc_control_tb
